//--- common/pie_pkg.sv
// Package: source table, register map, reset values and carriers of the interrupt expander
`default_nettype none
package pie_pkg;

    localparam int PIE_NSRC = 24;
    localparam int PIE_NLVL = 6;
    localparam int PIE_NGRP = 3;

    // Processor interrupt levels
    localparam logic [2:0] PIE_LVL_ONE = 3'h1;
    localparam logic [2:0] PIE_LVL_TWO = 3'h2;
    localparam logic [2:0] PIE_LVL_THREE = 3'h3;
    localparam logic [2:0] PIE_LVL_FOUR = 3'h4;
    localparam logic [2:0] PIE_LVL_FIVE = 3'h5;
    localparam logic [2:0] PIE_LVL_SIX = 3'h6;

    localparam logic [15:0] PIE_PHANTOM_VEC = 16'h0000;

    // One table entry: flat request bit (group * 16 + bit), vector code, level
    typedef struct packed {
        logic [5:0] flat_bit;
        logic [15:0] vec;
        logic [2:0] lvl;
    } pie_src_t;

    // Entry positions; lower position wins within a level
    localparam int PIE_E_SPI_HI = 0;
    localparam int PIE_E_T1_PER = 1;
    localparam int PIE_E_T2_PER = 2;
    localparam int PIE_E_T2_CMP = 3;
    localparam int PIE_E_T2_UND = 4;
    localparam int PIE_E_T2_OVF = 5;
    localparam int PIE_E_T4_PER = 6;
    localparam int PIE_E_T4_CMP = 7;
    localparam int PIE_E_T4_UND = 8;
    localparam int PIE_E_T4_OVF = 9;
    localparam int PIE_E_CAP1 = 10;
    localparam int PIE_E_CAP4 = 13;
    localparam int PIE_E_SPI_LO = 16;
    localparam int PIE_E_ASYNC_RX = 17;
    localparam int PIE_E_ASYNC_TX = 18;
    localparam int PIE_E_CAN_MB = 19;
    localparam int PIE_E_CAN_ERR = 20;
    localparam int PIE_E_CONV = 21;
    localparam int PIE_E_PIN_ONE = 22;
    localparam int PIE_E_PIN_TWO = 23;

    // Ordered by overall priority
    localparam pie_src_t PIE_SRC [PIE_NSRC] = '{
        '{6'h04, 16'h0005, PIE_LVL_ONE},
        '{6'h0C, 16'h0027, PIE_LVL_TWO},
        '{6'h10, 16'h002B, PIE_LVL_THREE},
        '{6'h11, 16'h002C, PIE_LVL_THREE},
        '{6'h12, 16'h002D, PIE_LVL_THREE},
        '{6'h13, 16'h002E, PIE_LVL_THREE},
        '{6'h28, 16'h0039, PIE_LVL_THREE},
        '{6'h29, 16'h003A, PIE_LVL_THREE},
        '{6'h2A, 16'h003B, PIE_LVL_THREE},
        '{6'h2B, 16'h003C, PIE_LVL_THREE},
        '{6'h14, 16'h0033, PIE_LVL_FOUR},
        '{6'h15, 16'h0034, PIE_LVL_FOUR},
        '{6'h16, 16'h0035, PIE_LVL_FOUR},
        '{6'h2C, 16'h0036, PIE_LVL_FOUR},
        '{6'h2D, 16'h0037, PIE_LVL_FOUR},
        '{6'h2E, 16'h0038, PIE_LVL_FOUR},
        '{6'h17, 16'h0005, PIE_LVL_FIVE},
        '{6'h18, 16'h0006, PIE_LVL_FIVE},
        '{6'h19, 16'h0007, PIE_LVL_FIVE},
        '{6'h1A, 16'h0040, PIE_LVL_FIVE},
        '{6'h1B, 16'h0041, PIE_LVL_FIVE},
        '{6'h1C, 16'h0004, PIE_LVL_SIX},
        '{6'h1D, 16'h0001, PIE_LVL_SIX},
        '{6'h1E, 16'h0011, PIE_LVL_SIX}
    };

    // Register byte offsets (low address byte)
    localparam logic [7:0] PIE_OFS_REQ [PIE_NGRP] = '{8'h00, 8'h04, 8'h08};
    localparam logic [7:0] PIE_OFS_EN [PIE_NGRP] = '{8'h0C, 8'h10, 8'h14};
    localparam logic [7:0] PIE_OFS_CTRL = 8'h18;
    localparam logic [7:0] PIE_OFS_STATUS = 8'h1C;
    localparam logic [7:0] PIE_OFS_MASK = 8'h20;
    localparam logic [7:0] PIE_OFS_LASTVEC = 8'h24;

    // Control and status fields
    localparam int PIE_CTRL_SPI_HI = 0;
    localparam int PIE_ST_W = 2;
    localparam int PIE_ST_PHANTOM = 0;
    localparam int PIE_ST_OVERRUN = 1;

    // Reset values
    localparam logic [47:0] PIE_RST_EN = 48'h0000_0000_0000;
    localparam logic PIE_RST_CTRL = 1'b0;
    localparam logic [PIE_ST_W-1:0] PIE_RST_ST = 2'h0;
    localparam logic [PIE_ST_W-1:0] PIE_RST_MASK = 2'h0;

    // Peripheral request lines; the two pin lines are asynchronous
    typedef struct packed {
        logic timer1_period_irq;
        logic timer2_period_irq;
        logic timer2_compare_irq;
        logic timer2_underflow_irq;
        logic timer2_overflow_irq;
        logic timer4_period_irq;
        logic timer4_compare_irq;
        logic timer4_underflow_irq;
        logic timer4_overflow_irq;
        logic capture_one_irq;
        logic capture_two_irq;
        logic capture_three_irq;
        logic capture_four_irq;
        logic capture_five_irq;
        logic capture_six_irq;
        logic serial_periph_irq;
        logic async_receive_irq;
        logic async_transmit_irq;
        logic can_mailbox_irq;
        logic can_fault_irq;
        logic converter_irq;
        logic ext_pin_one_irq;
        logic ext_pin_two_irq;
    } pie_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] lvl;
    } pie_ack_t;

    typedef struct packed {
        logic valid;
        logic [15:0] vec;
    } pie_vec_t;

endpackage : pie_pkg
`default_nettype wire

//--- rtl/pie_prio_pick.sv
// Priority pick of the first live entry on one processor level
`default_nettype none
module pie_prio_pick
    import pie_pkg::*;
(
    input wire logic [PIE_NSRC-1:0] live_in,
    input wire logic [2:0] lvl_in,
    output logic hit_out,
    output logic [PIE_NSRC-1:0] sel_out,
    output logic [15:0] vec_out
);

    logic [PIE_NSRC:0] seen;
    logic [15:0] vacc [PIE_NSRC+1];

    assign seen[0] = 1'b0;
    assign vacc[0] = PIE_PHANTOM_VEC;

    // Chain keeps only the first hit, so the table order is the priority
    genvar i;
    generate
        for (i = 0; i < PIE_NSRC; i++) begin : g_ent
            logic hit;
            assign hit = live_in[i] && (PIE_SRC[i].lvl == lvl_in);
            assign sel_out[i] = hit && !seen[i];
            assign seen[i+1] = seen[i] || hit;
            assign vacc[i+1] = sel_out[i] ? PIE_SRC[i].vec : vacc[i];
        end
    endgenerate

    assign hit_out = seen[PIE_NSRC];
    assign vec_out = vacc[PIE_NSRC];

endmodule : pie_prio_pick
`default_nettype wire

//--- rtl/pie_expander.sv
// Peripheral interrupt expander: request latching, level lines, acknowledge and AHB-Lite registers
`default_nettype none
module pie_expander
    import pie_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire pie_req_t req_in,
    input wire pie_ack_t ack_in,
    output var pie_vec_t vec_out,
    output logic [PIE_NLVL-1:0] cpu_level_out,
    output logic irq_out,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r, pin_agree, pin_lvl_nxt;
    logic [PIE_NSRC-1:0] req_flat, req_prev_r, rise, pend_r, pend_nxt, live;
    logic [PIE_NSRC-1:0] en_live, sw_clr, ack_clr, pick_sel;
    logic [15:0] pick_vec, last_vec_r;
    logic [47:0] req48, en_r, en_nxt, sw_clr48;
    logic [PIE_NLVL-1:0] lvl_any, cpu_level_r;
    logic [PIE_ST_W-1:0] status_r, status_nxt, st_set, st_w1c, mask_r;
    logic pick_hit, ctrl_spi_hi_r, irq_r, ahb_take, wr_act_r, hready_r, hresp_r;
    pie_vec_t vec_r;
    logic [7:0] wr_ofs_r, rd_ofs;
    logic [31:0] rd_nxt, hrdata_r;
    logic [PIE_NGRP-1:0] wr_req_sel, wr_en_sel;
    logic wr_ctrl_sel, wr_st_sel, wr_mask_sel;

    // Pin lines: three stages, level moves only when stages two and three agree
    assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
    assign pin_lvl_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_lvl_r);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_lvl_r <= '0;
        end else begin
            pin_s1_r <= {req_in.ext_pin_two_irq, req_in.ext_pin_one_irq};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    assign req_flat[PIE_E_SPI_HI] = req_in.serial_periph_irq && ctrl_spi_hi_r;
    assign req_flat[PIE_E_T1_PER] = req_in.timer1_period_irq;
    assign req_flat[PIE_E_T2_PER] = req_in.timer2_period_irq;
    assign req_flat[PIE_E_T2_CMP] = req_in.timer2_compare_irq;
    assign req_flat[PIE_E_T2_UND] = req_in.timer2_underflow_irq;
    assign req_flat[PIE_E_T2_OVF] = req_in.timer2_overflow_irq;
    assign req_flat[PIE_E_T4_PER] = req_in.timer4_period_irq;
    assign req_flat[PIE_E_T4_CMP] = req_in.timer4_compare_irq;
    assign req_flat[PIE_E_T4_UND] = req_in.timer4_underflow_irq;
    assign req_flat[PIE_E_T4_OVF] = req_in.timer4_overflow_irq;
    assign req_flat[PIE_E_CAP4-1:PIE_E_CAP1] = {req_in.capture_three_irq, req_in.capture_two_irq,
                                                req_in.capture_one_irq};
    assign req_flat[PIE_E_SPI_LO-1:PIE_E_CAP4] = {req_in.capture_six_irq, req_in.capture_five_irq,
                                                  req_in.capture_four_irq};
    assign req_flat[PIE_E_SPI_LO] = req_in.serial_periph_irq && !ctrl_spi_hi_r;
    assign req_flat[PIE_E_ASYNC_RX] = req_in.async_receive_irq;
    assign req_flat[PIE_E_ASYNC_TX] = req_in.async_transmit_irq;
    assign req_flat[PIE_E_CAN_MB] = req_in.can_mailbox_irq;
    assign req_flat[PIE_E_CAN_ERR] = req_in.can_fault_irq;
    assign req_flat[PIE_E_CONV] = req_in.converter_irq;
    assign req_flat[PIE_E_PIN_ONE] = pin_lvl_r[0];
    assign req_flat[PIE_E_PIN_TWO] = pin_lvl_r[1];

    // Rising edges latch; a line held high raises one request only
    assign rise = req_flat & ~req_prev_r;
    assign live = pend_r & en_live;

    // Requests visible at their bit positions; unused positions read zero
    always_comb begin
        req48 = '0;
        en_live = '0;
        sw_clr = '0;
        lvl_any = '0;
        for (int i = 0; i < PIE_NSRC; i++) begin
            req48[PIE_SRC[i].flat_bit] = pend_r[i];
            en_live[i] = en_r[PIE_SRC[i].flat_bit];
            sw_clr[i] = sw_clr48[PIE_SRC[i].flat_bit];
            lvl_any[PIE_SRC[i].lvl - 3'h1] = lvl_any[PIE_SRC[i].lvl - 3'h1] | live[i];
        end
    end

    pie_prio_pick u_pick (
        .live_in(live),
        .lvl_in(ack_in.lvl),
        .hit_out(pick_hit),
        .sel_out(pick_sel),
        .vec_out(pick_vec)
    );

    assign ack_clr = ack_in.valid ? pick_sel : '0;
    // New edge wins over any clear in the same cycle
    assign pend_nxt = rise | (pend_r & ~(ack_clr | sw_clr));

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_prev_r <= '0;
            pend_r <= '0;
            cpu_level_r <= '0;
        end else begin
            req_prev_r <= req_flat;
            pend_r <= pend_nxt;
            cpu_level_r <= lvl_any;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vec_r <= '0;
            last_vec_r <= PIE_PHANTOM_VEC;
        end else begin
            vec_r.valid <= ack_in.valid;
            vec_r.vec <= ack_in.valid ? pick_vec : vec_r.vec;
            last_vec_r <= ack_in.valid ? pick_vec : last_vec_r;
        end
    end

    // Status events: phantom acknowledge, and an edge on a request still pending
    assign st_set[PIE_ST_PHANTOM] = ack_in.valid && !pick_hit;
    assign st_set[PIE_ST_OVERRUN] = |(rise & pend_r);
    assign st_w1c = wr_st_sel ? hwdata_in[PIE_ST_W-1:0] : '0;
    assign status_nxt = st_set | (status_r & ~st_w1c);

    // AHB-Lite: zero wait states, read data captured in the address phase
    assign ahb_take = hsel_in && htrans_in[1] && hready_in;
    assign rd_ofs = haddr_in[7:0];
    assign wr_ctrl_sel = wr_act_r && (wr_ofs_r == PIE_OFS_CTRL);
    assign wr_st_sel = wr_act_r && (wr_ofs_r == PIE_OFS_STATUS);
    assign wr_mask_sel = wr_act_r && (wr_ofs_r == PIE_OFS_MASK);

    genvar g;
    generate
        for (g = 0; g < PIE_NGRP; g++) begin : g_grp
            assign wr_req_sel[g] = wr_act_r && (wr_ofs_r == PIE_OFS_REQ[g]);
            assign wr_en_sel[g] = wr_act_r && (wr_ofs_r == PIE_OFS_EN[g]);
            assign en_nxt[g*16 +: 16] = wr_en_sel[g] ? hwdata_in[15:0] : en_r[g*16 +: 16];
            assign sw_clr48[g*16 +: 16] = wr_req_sel[g] ? hwdata_in[15:0] : 16'h0000;
        end
    endgenerate

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (rd_ofs == PIE_OFS_REQ[0]) begin
            rd_nxt[15:0] = req48[15:0];
        end else if (rd_ofs == PIE_OFS_REQ[1]) begin
            rd_nxt[15:0] = req48[31:16];
        end else if (rd_ofs == PIE_OFS_REQ[2]) begin
            rd_nxt[15:0] = req48[47:32];
        end else if (rd_ofs == PIE_OFS_EN[0]) begin
            rd_nxt[15:0] = en_r[15:0];
        end else if (rd_ofs == PIE_OFS_EN[1]) begin
            rd_nxt[15:0] = en_r[31:16];
        end else if (rd_ofs == PIE_OFS_EN[2]) begin
            rd_nxt[15:0] = en_r[47:32];
        end else if (rd_ofs == PIE_OFS_CTRL) begin
            rd_nxt[PIE_CTRL_SPI_HI] = ctrl_spi_hi_r;
        end else if (rd_ofs == PIE_OFS_STATUS) begin
            rd_nxt[PIE_ST_W-1:0] = status_r;
        end else if (rd_ofs == PIE_OFS_MASK) begin
            rd_nxt[PIE_ST_W-1:0] = mask_r;
        end else if (rd_ofs == PIE_OFS_LASTVEC) begin
            rd_nxt[15:0] = last_vec_r;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_act_r <= 1'b0;
            wr_ofs_r <= '0;
            hrdata_r <= '0;
        end else begin
            wr_act_r <= ahb_take && hwrite_in;
            wr_ofs_r <= ahb_take ? haddr_in[7:0] : wr_ofs_r;
            hrdata_r <= (ahb_take && !hwrite_in) ? rd_nxt : hrdata_r;
        end
    end

    // Constant responses, kept in flops so every output starts at a flop
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            en_r <= PIE_RST_EN;
            ctrl_spi_hi_r <= PIE_RST_CTRL;
            status_r <= PIE_RST_ST;
            mask_r <= PIE_RST_MASK;
            irq_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            ctrl_spi_hi_r <= wr_ctrl_sel ? hwdata_in[PIE_CTRL_SPI_HI] : ctrl_spi_hi_r;
            status_r <= status_nxt;
            mask_r <= wr_mask_sel ? hwdata_in[PIE_ST_W-1:0] : mask_r;
            irq_r <= |(status_r & mask_r);
        end
    end

    assign vec_out = vec_r;
    assign cpu_level_out = cpu_level_r;
    assign irq_out = irq_r;
    assign hrdata_out = hrdata_r;
    assign hreadyout_out = hready_r;
    assign hresp_out = hresp_r;

    property p_t2_period;
        ack_in.valid && ack_in.lvl == PIE_LVL_THREE && live[PIE_E_T2_PER]
            |=> vec_r.valid && vec_r.vec == PIE_SRC[PIE_E_T2_PER].vec;
    endproperty
    a_t2_period: assert property (p_t2_period) else $error("timer 2 period code wrong");

    property p_t2_compare;
        ack_in.valid && ack_in.lvl == PIE_LVL_THREE && live[PIE_E_T2_CMP] && !live[PIE_E_T2_PER]
            |=> vec_r.vec == PIE_SRC[PIE_E_T2_CMP].vec;
    endproperty
    a_t2_compare: assert property (p_t2_compare) else $error("timer 2 compare code wrong");

    property p_t2_under;
        ack_in.valid && ack_in.lvl == PIE_LVL_THREE && live[PIE_E_T2_UND] && !(|live[PIE_E_T2_CMP:PIE_E_T2_PER])
            |=> vec_r.vec == PIE_SRC[PIE_E_T2_UND].vec;
    endproperty
    a_t2_under: assert property (p_t2_under) else $error("timer 2 underflow code wrong");

    property p_t2_over_first;
        ack_in.valid && ack_in.lvl == PIE_LVL_THREE && live[PIE_E_T2_OVF] && live[PIE_E_T4_PER]
            && !(|live[PIE_E_T2_UND:PIE_E_T2_PER]) |=> vec_r.vec == PIE_SRC[PIE_E_T2_OVF].vec;
    endproperty
    a_t2_over_first: assert property (p_t2_over_first) else $error("timer 2 overflow lost to timer 4");

    property p_t4_period;
        ack_in.valid && ack_in.lvl == PIE_LVL_THREE && live[PIE_E_T4_PER] && !(|live[PIE_E_T2_OVF:PIE_E_T2_PER])
            |=> vec_r.vec == PIE_SRC[PIE_E_T4_PER].vec && (!pend_r[PIE_E_T4_PER] || $past(rise[PIE_E_T4_PER]));
    endproperty
    a_t4_period: assert property (p_t4_period) else $error("timer 4 period code wrong");

    property p_spi_low;
        !ctrl_spi_hi_r && rise[PIE_E_SPI_LO]
            |=> pend_r[PIE_E_SPI_LO] && (!pend_r[PIE_E_SPI_HI] || $past(pend_r[PIE_E_SPI_HI]));
    endproperty
    a_spi_low: assert property (p_spi_low) else $error("serial request not on level five");

    property p_can_mailbox;
        ack_in.valid && ack_in.lvl == PIE_LVL_FIVE && live[PIE_E_CAN_MB] && !(|live[PIE_E_ASYNC_TX:PIE_E_SPI_LO])
            |=> vec_r.vec == PIE_SRC[PIE_E_CAN_MB].vec;
    endproperty
    a_can_mailbox: assert property (p_can_mailbox) else $error("CAN mailbox code wrong");

    property p_spi_high;
        ctrl_spi_hi_r && rise[PIE_E_SPI_HI]
            |=> pend_r[PIE_E_SPI_HI] ##1 cpu_level_r[0] || !$past(en_live[PIE_E_SPI_HI]);
    endproperty
    a_spi_high: assert property (p_spi_high) else $error("serial request not on level one");

    property p_t1_level_two;
        live[PIE_E_T1_PER] |=> cpu_level_r[1];
    endproperty
    a_t1_level_two: assert property (p_t1_level_two) else $error("timer 1 not on level two");

    property p_capture_four;
        ack_in.valid && ack_in.lvl == PIE_LVL_FOUR && live[PIE_E_CAP1]
            |=> vec_r.vec == PIE_SRC[PIE_E_CAP1].vec;
    endproperty
    a_capture_four: assert property (p_capture_four) else $error("capture code wrong");

    property p_ack_clear;
        ack_in.valid && pick_hit && !(|(rise & pick_sel)) |=> !(|(pend_r & $past(pick_sel)));
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledged request not cleared");

    property p_phantom;
        ack_in.valid && !(|(live & ~pick_sel)) && !pick_hit
            |=> vec_r.valid && vec_r.vec == PIE_PHANTOM_VEC && status_r[PIE_ST_PHANTOM];
    endproperty
    a_phantom: assert property (p_phantom) else $error("phantom code not given");

endmodule : pie_expander
`default_nettype wire

//--- verif/pie_cpu_model.sv
// Processor-side acknowledge model for the interrupt expander
`default_nettype none
module pie_cpu_model
    import pie_pkg::*;
(
    input wire logic clk_in,
    input wire pie_vec_t vec_in,
    output pie_ack_t ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ack_out = '0;
    // One-cycle pulse; the answer strobe stands one cycle only, so look right after that edge
    task automatic acknowledge(input logic [2:0] lvl, output logic [15:0] vec, output logic ok);
        @(posedge clk_in);
        ack_out <= '{valid: 1'b1, lvl: lvl};
        @(posedge clk_in);
        ack_out <= '0;
        #1;
        ok = vec_in.valid;
        vec = vec_in.vec;
    endtask : acknowledge
endmodule : pie_cpu_model
`default_nettype wire

//--- verif/pie_expander_tb.sv
// Self-checking bench for the interrupt expander
`default_nettype none
module pie_expander_tb
    import pie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_in, hsel, hwrite, irq, hready, hresp;
    pie_req_t req;
    pie_ack_t ack;
    pie_vec_t vec;
    logic [5:0] lvl_w;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    int error_cnt = 0;
    int n_tests = 0;
    // Per request bit 22 down to 0: level, flat request bit, vector code
    int lv[23] = '{2, 3, 3, 3, 3, 3, 3, 3, 3, 4, 4, 4, 4, 4, 4, 5, 5, 5, 5, 5, 6, 6, 6};
    int fb[23] = '{12, 16, 17, 18, 19, 40, 41, 42, 43, 20, 21, 22, 44, 45, 46, 23, 24, 25, 26, 27, 28, 29, 30};
    logic [15:0] vc[23] = '{16'h0027, 16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0039, 16'h003A, 16'h003B,
        16'h003C, 16'h0033, 16'h0034, 16'h0035, 16'h0036, 16'h0037, 16'h0038, 16'h0005, 16'h0006, 16'h0007,
        16'h0040, 16'h0041, 16'h0004, 16'h0001, 16'h0011};
    pie_expander dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .ack_in(ack), .vec_out(vec),
        .cpu_level_out(lvl_w), .irq_out(irq), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp));
    pie_cpu_model cpu (.clk_in(clk_in), .vec_in(vec), .ack_out(ack));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Single word transfer; the leading edge leaves one idle cycle between transfers
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_in); while (hready !== 1'b1);
        q = hrdata;
        chk("okay", 0, hresp);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask : rd
    task automatic ackchk(input logic [2:0] l, input logic [15:0] e);
        logic [15:0] v;
        logic ok;
        cpu.acknowledge(l, v, ok);
        chk("vector strobe", 1, ok);
        chk("vector", e, v);
    endtask : ackchk
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        $display("mismatch watchdog expected done seen timeout");
        tally_and_finish();
    end
    initial begin
        rst_in = 1'b1;
        req = '0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        chk("levels after reset", 0, lvl_w);
        chk("irq after reset", 0, irq);
        rd(8'h10, 0, "enable reset");
        rd(8'h40, 0, "unmapped");
        wr(8'h0C, 32'h0000_1010);
        wr(8'h10, 32'h0000_7FFF);
        wr(8'h14, 32'h0000_7F00);
        // Every source but the high serial entry in turn: level line, request position, code, clear on acknowledge
        for (int i = 0; i < 23; i++) begin
            @(posedge clk_in);
            req[22-i] <= 1'b1;
            // Pin lines need three sync stages before the edge is seen
            repeat (8) @(posedge clk_in);
            chk("level line", 1, lvl_w[lv[i]-1]);
            rd(8'(fb[i] / 16 * 4), 32'(1) << (fb[i] % 16), "request bit");
            ackchk(3'(lv[i]), vc[i]);
            req[22-i] <= 1'b0;
            rd(8'(fb[i] / 16 * 4), 0, "request cleared");
            chk("level drop", 0, lvl_w[lv[i]-1]);
        end
        @(posedge clk_in);
        req.timer2_overflow_irq <= 1'b1;
        req.timer4_period_irq <= 1'b1;
        repeat (3) @(posedge clk_in);
        ackchk(PIE_LVL_THREE, 16'h002E);
        ackchk(PIE_LVL_THREE, 16'h0039);
        ackchk(PIE_LVL_THREE, 16'h0000);
        rd(8'h1C, 32'h0000_0001, "phantom status");
        rd(8'h24, 32'h0000_0000, "last vector");
        chk("irq while masked", 0, irq);
        wr(8'h20, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        chk("irq unmasked", 1, irq);
        wr(8'h1C, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        chk("irq cleared", 0, irq);
        rd(8'h1C, 0, "status cleared");
        req <= '0;
        wr(8'h18, 32'h0000_0001);
        @(posedge clk_in);
        req.serial_periph_irq <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("level one", 1, lvl_w[0]);
        rd(8'h00, 32'h0000_0010, "high request bit");
        ackchk(PIE_LVL_ONE, 16'h0005);
        tally_and_finish();
    end
endmodule : pie_expander_tb
`default_nettype wire
